//--- common/can_mode_params.svh
// offsets, field positions, reset values and counts of the mode control block
`ifndef CAN_MODE_PARAMS_SVH
`define CAN_MODE_PARAMS_SVH
`define CMC_ADDR_W        8
`define CMC_CTRL_OFF      8'h00
`define CMC_STAT_OFF      8'h04
`define CMC_IRQEN_OFF     8'h14
`define CMC_DBF_BIT       16
`define CMC_SWRST_BIT     15
`define CMC_TTE_BIT       7
`define CMC_ABR_BIT       6
`define CMC_AWU_BIT       5
`define CMC_NO_AUTO_RETRANSMIT_BIT      4
`define CMC_RX_FIFO_LOCK_MODE_BIT      3
`define CMC_TXO_BIT       2
`define CMC_SLPRQ_BIT     1
`define CMC_INIRQ_BIT     0
`define CMC_RXPIN_BIT     11
`define CMC_SAMPLED_RX_LEVEL_BIT      10
`define CMC_RXM_BIT       9
`define CMC_TXM_BIT       8
`define CMC_SLPF_BIT      4
`define CMC_WKF_BIT       3
`define CMC_ERRF_BIT      2
`define CMC_SLEEP_ACKNOWLEDGE_BIT      1
`define CMC_INIT_ACKNOWLEDGE_BIT      0
`define CMC_SLEEP_IRQ_ENABLE_BIT     17
`define CMC_WKUIE_BIT     16
`define CMC_ERROR_IRQ_ENABLE_BIT     15
`define CMC_RUN_BITS      11
`define CMC_SEQ_COUNT     128
`define CMC_DBF_RST       1'b1
`define CMC_SLPRQ_RST     1'b1
`endif

//--- common/can_mode_pkg.sv
// types of the mode control block
package can_mode_pkg;
	// controller operating mode, one-hot
	typedef enum logic [2:0] {
		MODE_SLEEP  = 3'b001,
		MODE_INIT   = 3'b010,
		MODE_NORMAL = 3'b100
	} mode_t;
	// software control fields
	typedef struct packed {
		logic debug_freeze;
		logic time_trigger_enable;
		logic auto_busoff_recovery;
		logic auto_wakeup_enable;
		logic no_auto_retransmit;
		logic rx_fifo_lock_mode;
		logic tx_order_priority;
		logic sleep_request;
		logic init_request;
	} ctrl_t;
	// whole block state
	typedef struct packed {
		mode_t       mode;
		ctrl_t       ctrl;
		logic        sw_reset;
		logic        sleep_irq_enable;
		logic        wakeup_irq_enable;
		logic        error_irq_enable;
		logic        sleep_entry_flag;
		logic        wakeup_flag;
		logic        error_flag;
		logic        sampled_rx_level;
		logic        bus_off;
		logic        recovery_armed;
		logic [7:0]  run_cnt;
		logic [15:0] seq_cnt;
		logic [31:0] rdata;
	} state_t;
endpackage

//--- verilog/can_mode_control.sv
// mode control and status logic of the bus controller
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`include "can_mode_params.svh"

// Behaviour
// - debug halt with freeze keeps transmit recessive
// - software reset reloads all, enters sleep
// - time trigger output follows its bit
// - auto recovery leaves bus-off after sequences
// - manual recovery needs init set then cleared
// - auto wake on frame clears sleep bits
// - retransmit disable passed to transmit engine
// - fifo lock mode passed to receive engine
// - transmit order select passed to arbiter
// - sleep entered from normal when idle, from init at once; left on clear
// - init entered from normal when idle, from sleep at once; acknowledge follows
// - status shows live receive pin level
// - status shows last sampled receive bit
// - status shows transmitter activity
// - sleep entry flag sets, write one clears
// - wake flag sets on frame start asleep
// - error flag sets on error event
// - sleep acknowledge exactly in sleep mode
// - init acknowledge exactly in init mode
// - init acknowledge zero outside init mode
module can_mode_control #(
	parameter int RUN_BITS  = `CMC_RUN_BITS,   // recessive bits forming one idle sequence
	parameter int SEQ_COUNT = `CMC_SEQ_COUNT   // idle sequences needed to leave bus-off
) (
	input  wire logic                   SYS_CLK_IN,
	input  wire logic                   RST_N_IN,
	input  wire logic [`CMC_ADDR_W-1:0] REG_ADDR_IN,
	input  wire logic [31:0]            REG_WDATA_IN,
	input  wire logic                   REG_WR_IN,
	input  wire logic                   REG_RD_IN,
	output logic      [31:0]            REG_RDATA_OUT,
	input  wire logic                   CAN_RX_IN,
	output logic                        CAN_TX_OUT,
	input  wire logic                   CORE_TX_IN,
	input  wire logic                   DEBUG_HALT_IN,
	input  wire logic                   BIT_SAMPLE_IN,
	input  wire logic                   BUS_IDLE_IN,
	input  wire logic                   SOF_DETECT_IN,
	input  wire logic                   TX_ACTIVE_IN,
	input  wire logic                   RX_ACTIVE_IN,
	input  wire logic                   ERROR_EVENT_IN,
	input  wire logic                   BUS_OFF_ENTER_IN,
	output logic                        CORE_RESET_OUT,
	output logic                        SLEEP_MODE_OUT,
	output logic                        INIT_MODE_OUT,
	output logic                        BUS_OFF_OUT,
	output logic                        TIME_TRIGGER_OUT,
	output logic                        NO_RETRANSMIT_OUT,
	output logic                        RX_LOCK_OUT,
	output logic                        TX_ORDER_OUT
);

	// counters are 8 and 16 bits wide in the state struct, so larger counts cannot be served
	if (RUN_BITS < 1 || RUN_BITS > 255 ||
	    SEQ_COUNT < 1 || SEQ_COUNT > 65535) begin : g_bad_counts
		$error("recovery counts out of range");
	end

	localparam logic [7:0]  RUN_LAST = 8'(RUN_BITS - 1);   // last bit of a sequence
	localparam logic [15:0] SEQ_LAST = 16'(SEQ_COUNT - 1); // last sequence before exit

	can_mode_pkg::state_t st;        // registered state
	can_mode_pkg::state_t next_st;   // next state
	can_mode_pkg::state_t rst_st;    // reset image, also used by software reset

	logic wr_ctrl;      // write to control register
	logic wr_stat;      // write to status register
	logic wr_irqen;     // write to irq enable register
	logic idle_ok;      // current bus activity has completed
	logic frozen;       // transceiver prohibited by debug
	logic entering_sleep; // mode changes to sleep this cycle

	// reset image of every field
	always_comb begin
		rst_st                        = '0;
		rst_st.mode                   = can_mode_pkg::MODE_SLEEP;
		rst_st.ctrl.debug_freeze      = `CMC_DBF_RST;
		rst_st.ctrl.sleep_request     = `CMC_SLPRQ_RST;
		rst_st.sampled_rx_level       = 1'b1;
	end

	// register decode; other addresses are ignored on write and read zero
	assign wr_ctrl  = REG_WR_IN && (REG_ADDR_IN == `CMC_CTRL_OFF);
	assign wr_stat  = REG_WR_IN && (REG_ADDR_IN == `CMC_STAT_OFF);
	assign wr_irqen = REG_WR_IN && (REG_ADDR_IN == `CMC_IRQEN_OFF);
	assign idle_ok  = BUS_IDLE_IN && !TX_ACTIVE_IN && !RX_ACTIVE_IN;
	assign frozen   = st.ctrl.debug_freeze && DEBUG_HALT_IN;

	// next state: registers, mode machine, flags, recovery counters, read data
	always_comb begin
		next_st        = st;
		entering_sleep = 1'b0;
		// software control writes; reserved bits are dropped
		if (wr_ctrl) begin
			next_st.ctrl.debug_freeze         = REG_WDATA_IN[`CMC_DBF_BIT];
			next_st.ctrl.time_trigger_enable  = REG_WDATA_IN[`CMC_TTE_BIT];
			next_st.ctrl.auto_busoff_recovery = REG_WDATA_IN[`CMC_ABR_BIT];
			next_st.ctrl.auto_wakeup_enable   = REG_WDATA_IN[`CMC_AWU_BIT];
			next_st.ctrl.no_auto_retransmit   = REG_WDATA_IN[`CMC_NO_AUTO_RETRANSMIT_BIT];
			next_st.ctrl.rx_fifo_lock_mode    = REG_WDATA_IN[`CMC_RX_FIFO_LOCK_MODE_BIT];
			next_st.ctrl.tx_order_priority    = REG_WDATA_IN[`CMC_TXO_BIT];
			next_st.ctrl.sleep_request        = REG_WDATA_IN[`CMC_SLPRQ_BIT];
			next_st.ctrl.init_request         = REG_WDATA_IN[`CMC_INIRQ_BIT];
			// writing zero to the reset bit does nothing
			if (REG_WDATA_IN[`CMC_SWRST_BIT]) begin
				next_st.sw_reset = 1'b1;
			end
		end
		if (wr_irqen) begin
			next_st.sleep_irq_enable  = REG_WDATA_IN[`CMC_SLEEP_IRQ_ENABLE_BIT];
			next_st.wakeup_irq_enable = REG_WDATA_IN[`CMC_WKUIE_BIT];
			next_st.error_irq_enable  = REG_WDATA_IN[`CMC_ERROR_IRQ_ENABLE_BIT];
		end
		// manual recovery: init request seen high and then low again
		if (st.bus_off && st.ctrl.init_request && !next_st.ctrl.init_request) begin
			next_st.recovery_armed = 1'b1;
		end
		// flag clears by writing one; the set below overrides a same-cycle clear
		if (wr_stat) begin
			if (REG_WDATA_IN[`CMC_SLPF_BIT]) begin
				next_st.sleep_entry_flag = 1'b0;
			end
			if (REG_WDATA_IN[`CMC_WKF_BIT]) begin
				next_st.wakeup_flag = 1'b0;
			end
			if (REG_WDATA_IN[`CMC_ERRF_BIT]) begin
				next_st.error_flag = 1'b0;
			end
		end
		// mode machine; requests in normal mode wait for the bus to go quiet
		unique case (st.mode)
			can_mode_pkg::MODE_SLEEP: begin
				if (SOF_DETECT_IN && st.ctrl.auto_wakeup_enable) begin
					// hardware wake clears the request; acknowledge drops with the mode
					next_st.ctrl.sleep_request = 1'b0;
					next_st.mode = st.ctrl.init_request ? can_mode_pkg::MODE_INIT
					                                    : can_mode_pkg::MODE_NORMAL;
				end else if (!st.ctrl.sleep_request) begin
					next_st.mode = st.ctrl.init_request ? can_mode_pkg::MODE_INIT
					                                    : can_mode_pkg::MODE_NORMAL;
				end
			end
			can_mode_pkg::MODE_INIT: begin
				// no bus activity in init, so leaving is immediate
				if (!st.ctrl.init_request) begin
					next_st.mode = st.ctrl.sleep_request ? can_mode_pkg::MODE_SLEEP
					                                     : can_mode_pkg::MODE_NORMAL;
					entering_sleep = st.ctrl.sleep_request;
				end
			end
			can_mode_pkg::MODE_NORMAL: begin
				if (idle_ok && st.ctrl.init_request) begin
					next_st.mode = can_mode_pkg::MODE_INIT;
				end else if (idle_ok && st.ctrl.sleep_request) begin
					next_st.mode   = can_mode_pkg::MODE_SLEEP;
					entering_sleep = 1'b1;
				end
			end
		endcase
		// sleep entry flag is dropped by hardware on leaving sleep
		if (st.mode == can_mode_pkg::MODE_SLEEP &&
		    next_st.mode != can_mode_pkg::MODE_SLEEP) begin
			next_st.sleep_entry_flag = 1'b0;
		end
		// event sets come last so that they win over clears
		if (entering_sleep && st.sleep_irq_enable) begin
			next_st.sleep_entry_flag = 1'b1;
		end
		if (st.mode == can_mode_pkg::MODE_SLEEP && SOF_DETECT_IN && st.wakeup_irq_enable) begin
			next_st.wakeup_flag = 1'b1;
		end
		if (ERROR_EVENT_IN && st.error_irq_enable) begin
			next_st.error_flag = 1'b1;
		end
		// sampled receive level
		if (BIT_SAMPLE_IN) begin
			next_st.sampled_rx_level = CAN_RX_IN;
		end
		// bus-off recovery by counting runs of recessive bits
		if (BUS_OFF_ENTER_IN) begin
			next_st.bus_off        = 1'b1;
			next_st.recovery_armed = 1'b0;
			next_st.run_cnt        = '0;
			next_st.seq_cnt        = '0;
		end else if (st.bus_off && BIT_SAMPLE_IN &&
		             (st.ctrl.auto_busoff_recovery || st.recovery_armed)) begin
			if (!CAN_RX_IN) begin
				// a dominant bit breaks the current run only
				next_st.run_cnt = '0;
			end else if (st.run_cnt != RUN_LAST) begin
				next_st.run_cnt = st.run_cnt + 8'h01;
			end else if (st.seq_cnt != SEQ_LAST) begin
				next_st.run_cnt = '0;
				next_st.seq_cnt = st.seq_cnt + 16'h0001;
			end else begin
				next_st.bus_off        = 1'b0;
				next_st.recovery_armed = 1'b0;
				next_st.run_cnt        = '0;
				next_st.seq_cnt        = '0;
			end
		end
		// read data, valid the cycle after the strobe only
		next_st.rdata = '0;
		if (REG_RD_IN) begin
			unique case (REG_ADDR_IN)
				`CMC_CTRL_OFF: begin
					next_st.rdata[`CMC_DBF_BIT]   = st.ctrl.debug_freeze;
					next_st.rdata[`CMC_SWRST_BIT] = st.sw_reset;
					next_st.rdata[`CMC_TTE_BIT]   = st.ctrl.time_trigger_enable;
					next_st.rdata[`CMC_ABR_BIT]   = st.ctrl.auto_busoff_recovery;
					next_st.rdata[`CMC_AWU_BIT]   = st.ctrl.auto_wakeup_enable;
					next_st.rdata[`CMC_NO_AUTO_RETRANSMIT_BIT]  = st.ctrl.no_auto_retransmit;
					next_st.rdata[`CMC_RX_FIFO_LOCK_MODE_BIT]  = st.ctrl.rx_fifo_lock_mode;
					next_st.rdata[`CMC_TXO_BIT]   = st.ctrl.tx_order_priority;
					next_st.rdata[`CMC_SLPRQ_BIT] = st.ctrl.sleep_request;
					next_st.rdata[`CMC_INIRQ_BIT] = st.ctrl.init_request;
				end
				`CMC_STAT_OFF: begin
					next_st.rdata[`CMC_RXPIN_BIT] = CAN_RX_IN;
					next_st.rdata[`CMC_SAMPLED_RX_LEVEL_BIT]  = st.sampled_rx_level;
					next_st.rdata[`CMC_RXM_BIT]   = RX_ACTIVE_IN;
					next_st.rdata[`CMC_TXM_BIT]   = TX_ACTIVE_IN;
					next_st.rdata[`CMC_SLPF_BIT]  = st.sleep_entry_flag;
					next_st.rdata[`CMC_WKF_BIT]   = st.wakeup_flag;
					next_st.rdata[`CMC_ERRF_BIT]  = st.error_flag;
					next_st.rdata[`CMC_SLEEP_ACKNOWLEDGE_BIT]  = (st.mode == can_mode_pkg::MODE_SLEEP);
					next_st.rdata[`CMC_INIT_ACKNOWLEDGE_BIT]  = (st.mode == can_mode_pkg::MODE_INIT);
				end
				`CMC_IRQEN_OFF: begin
					next_st.rdata[`CMC_SLEEP_IRQ_ENABLE_BIT] = st.sleep_irq_enable;
					next_st.rdata[`CMC_WKUIE_BIT] = st.wakeup_irq_enable;
					next_st.rdata[`CMC_ERROR_IRQ_ENABLE_BIT] = st.error_irq_enable;
				end
				default: begin
					next_st.rdata = '0;
				end
			endcase
		end
		// software reset: one cycle later everything reloads and the bit self-clears
		if (st.sw_reset) begin
			next_st       = rst_st;
			next_st.rdata = '0;
		end
	end

	// state register
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			st <= '{mode: can_mode_pkg::MODE_SLEEP,
			        ctrl: '{debug_freeze: `CMC_DBF_RST, sleep_request: `CMC_SLPRQ_RST,
			                default: 1'b0},
			        sampled_rx_level: 1'b1,
			        default: '0};
		end else begin
			st <= next_st;
		end
	end

	// outputs; transmit is held recessive while frozen so the bus sees nothing
	assign CAN_TX_OUT        = frozen ? 1'b1 : CORE_TX_IN;
	assign REG_RDATA_OUT     = st.rdata;
	assign CORE_RESET_OUT    = st.sw_reset;
	assign SLEEP_MODE_OUT    = (st.mode == can_mode_pkg::MODE_SLEEP);
	assign INIT_MODE_OUT     = (st.mode == can_mode_pkg::MODE_INIT);
	assign BUS_OFF_OUT       = st.bus_off;
	assign TIME_TRIGGER_OUT  = st.ctrl.time_trigger_enable;
	assign NO_RETRANSMIT_OUT = st.ctrl.no_auto_retransmit;
	assign RX_LOCK_OUT       = st.ctrl.rx_fifo_lock_mode;
	assign TX_ORDER_OUT      = st.ctrl.tx_order_priority;

	// checks on the block's own behaviour
	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RST_N_IN);

	freeze_tx_a: assert property (frozen |-> CAN_TX_OUT)
		else $error("transmit driven while frozen");
	swrst_sleep_a: assert property (wr_ctrl && REG_WDATA_IN[`CMC_SWRST_BIT] && !st.sw_reset
		|=> st.sw_reset ##1 (!st.sw_reset && SLEEP_MODE_OUT && st.ctrl.sleep_request))
		else $error("software reset did not reach sleep");
	tte_follow_a: assert property (wr_ctrl && !st.sw_reset
		|=> TIME_TRIGGER_OUT == $past(REG_WDATA_IN[`CMC_TTE_BIT]))
		else $error("time trigger not following write");
	busoff_exit_a: assert property ($fell(st.bus_off) && !$past(st.sw_reset) |->
		$past(BIT_SAMPLE_IN && CAN_RX_IN && st.seq_cnt == SEQ_LAST))
		else $error("bus-off left without full sequence count");
	manual_hold_a: assert property (st.bus_off && !st.ctrl.auto_busoff_recovery
		&& !st.recovery_armed && !st.sw_reset |=> st.bus_off)
		else $error("bus-off left without software sequence");
	auto_wake_a: assert property (SLEEP_MODE_OUT && SOF_DETECT_IN && st.ctrl.auto_wakeup_enable
		&& !st.sw_reset && !wr_ctrl |=> !SLEEP_MODE_OUT && !st.ctrl.sleep_request)
		else $error("auto wake did not clear sleep");
	sleep_wait_a: assert property (st.mode == can_mode_pkg::MODE_NORMAL && !idle_ok
		&& !st.sw_reset |=> st.mode == can_mode_pkg::MODE_NORMAL)
		else $error("mode left while bus busy");
	init_ack_a: assert property (INIT_MODE_OUT && !st.ctrl.init_request && !st.sw_reset
		|=> !INIT_MODE_OUT)
		else $error("init mode kept after request cleared");
	stat_read_a: assert property (REG_RD_IN && REG_ADDR_IN == `CMC_STAT_OFF && !st.sw_reset
		|=> REG_RDATA_OUT[`CMC_INIT_ACKNOWLEDGE_BIT] == $past(INIT_MODE_OUT)
		&& REG_RDATA_OUT[`CMC_SLEEP_ACKNOWLEDGE_BIT] == $past(SLEEP_MODE_OUT)
		&& REG_RDATA_OUT[31:12] == 20'h00000)
		else $error("status read wrong");
	err_set_a: assert property (ERROR_EVENT_IN && st.error_irq_enable && !st.sw_reset
		|=> st.error_flag)
		else $error("error flag lost");
	wake_set_a: assert property (SLEEP_MODE_OUT && SOF_DETECT_IN && st.wakeup_irq_enable
		&& !st.sw_reset |=> st.wakeup_flag)
		else $error("wake flag lost");
	sampled_rx_level_hold_a: assert property (!BIT_SAMPLE_IN && !st.sw_reset
		|=> $stable(st.sampled_rx_level))
		else $error("sampled level changed without sample");

	sleep_to_normal_c: cover property (SLEEP_MODE_OUT ##1 !SLEEP_MODE_OUT && !INIT_MODE_OUT);
	init_cycle_c: cover property (INIT_MODE_OUT ##[1:20] !INIT_MODE_OUT);
	recovery_c: cover property ($fell(st.bus_off));
	swrst_c: cover property (st.sw_reset);

endmodule // can_mode_control

//--- verification/bus_node_model.sv
// far side model: one bus node seen through the transceiver
`timescale 1ns/10ps
module bus_node_model (
	input  wire logic clk_in,     // system clock
	input  wire logic tx_in,      // controller transmit pin
	output logic      rx_out,     // bus level at the receive pin
	output logic      sample_out, // one received bit sampled
	output logic      sof_out     // start of frame seen
);
	logic drive = 1'b1; // our own driver, recessive when released
	// wired-and bus: a dominant bit from either node wins
	assign rx_out = drive & tx_in;
	initial begin
		sample_out = 1'b0;
		sof_out = 1'b0;
	end
	// n bits at one level, each with its own strobe; the line keeps the level
	task send(input int n, input logic lvl);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_in);
			drive <= lvl;
			sample_out <= 1'b1;
			@(posedge clk_in);
			sample_out <= 1'b0;
		end
	endtask
	// let go: the bus floats back to recessive
	task let_go;
		@(posedge clk_in);
		drive <= 1'b1;
	endtask
	// a frame begins on the bus
	task frame_start;
		@(posedge clk_in);
		sof_out <= 1'b1;
		@(posedge clk_in);
		sof_out <= 1'b0;
	endtask
endmodule // bus_node_model

//--- verification/can_mode_control_test.sv
// self-checking bench of the mode control block
`timescale 1ns/10ps
`include "can_mode_params.svh"
module can_mode_control_test;
	logic        clk, rst_n, wr, rd, core_tx, halt, idle, tx_act, rx_act, err_ev, boff_ev;
	logic [7:0]  addr;      // register address
	logic [31:0] wdata;     // register write data
	logic [31:0] rdata;     // register read data
	logic        rx, smp, sof, tx, core_rst, slp, ini, boff, tte, nrt, lck, ord;
	int          rst_cnt;   // counts cycles in which the core reset pulse stands
	int          error_cnt, num_checks, cyc;
	localparam logic [7:0] CTL = `CMC_CTRL_OFF;  // control register
	localparam logic [7:0] STA = `CMC_STAT_OFF;  // status register
	localparam logic [7:0] IEN = `CMC_IRQEN_OFF; // irq enable register

	// small counts keep bus-off recovery short
	can_mode_control #(.RUN_BITS(2), .SEQ_COUNT(2)) can_mode_control_i (
		.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
		.REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .CAN_RX_IN(rx),
		.CAN_TX_OUT(tx), .CORE_TX_IN(core_tx), .DEBUG_HALT_IN(halt),
		.BIT_SAMPLE_IN(smp), .BUS_IDLE_IN(idle), .SOF_DETECT_IN(sof),
		.TX_ACTIVE_IN(tx_act), .RX_ACTIVE_IN(rx_act), .ERROR_EVENT_IN(err_ev),
		.BUS_OFF_ENTER_IN(boff_ev), .CORE_RESET_OUT(core_rst), .SLEEP_MODE_OUT(slp),
		.INIT_MODE_OUT(ini), .BUS_OFF_OUT(boff), .TIME_TRIGGER_OUT(tte),
		.NO_RETRANSMIT_OUT(nrt), .RX_LOCK_OUT(lck), .TX_ORDER_OUT(ord));
	bus_node_model bus_node_model_i (.clk_in(clk), .tx_in(tx), .rx_out(rx),
		.sample_out(smp), .sof_out(sof));

	// clock at 40 MHz
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// hang guard, far above the two hundred or so cycles the tests need
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			error_cnt++;
			summarize();
		end
	end
	// pulse counter; a single writer keeps the count free of races
	always @(posedge clk) begin
		if (core_rst === 1'b1)
			rst_cnt <= rst_cnt + 1;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one-cycle write strobe
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// one-cycle read strobe; data stand only in the following cycle
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 check(rdata, exp);
	endtask
	// wait whole cycles, then let the edge's updates land
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// 0 pulses the error event, else the bus-off entry
	task pulse(input int which);
		@(posedge clk);
		if (which == 0)
			err_ev <= 1'b1;
		else
			boff_ev <= 1'b1;
		@(posedge clk);
		err_ev <= 1'b0;
		boff_ev <= 1'b0;
	endtask
	task done(input string name);
		$display("test %s done", name);
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		{rst_n, wr, rd, halt, tx_act, rx_act, err_ev, boff_ev} = '0;
		{core_tx, idle} = 2'b11;
		addr = 8'h00;
		wdata = 32'h00000000;
		error_cnt = 0;
		num_checks = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		// reset values, unmapped and reserved places
		check(32'(slp), 32'h1);
		rd_chk(CTL, 32'h00010002);
		rd_chk(STA, 32'h00000c02);
		rd_chk(IEN, 32'h00000000);
		wr_reg(8'h40, 32'hffffffff);
		rd_chk(8'h40, 32'h00000000);
		rd_chk(CTL, 32'h00010002);
		done("reset");
		// software clears the sleep request to wake
		wr_reg(CTL, 32'h00010000);
		tick(3);
		check(32'(slp), 32'h0);
		rd_chk(STA, 32'h00000c00);
		// freeze holds the transmitter recessive only while enabled
		halt <= 1'b1;
		core_tx <= 1'b0;
		tick(1);
		check(32'(tx), 32'h1);
		wr_reg(CTL, 32'h00000000);
		tick(1);
		check(32'(tx), 32'h0);
		halt <= 1'b0;
		core_tx <= 1'b1;
		done("wake_freeze");
		// mode bits with every reserved bit also written
		wr_reg(CTL, 32'hfffe7f9c);
		rd_chk(CTL, 32'h0000009c);
		tick(2);
		check(32'({tte, nrt, lck, ord, slp, ini}), 32'h3c);
		wr_reg(CTL, 32'h00000000);
		tick(2);
		check(32'({tte, nrt, lck, ord}), 32'h0);
		done("mode_bits");
		// init waits for the bus to go idle
		idle <= 1'b0;
		wr_reg(CTL, 32'h00000001);
		tick(5);
		check(32'(ini), 32'h0);
		idle <= 1'b1;
		tick(3);
		check(32'(ini), 32'h1);
		rd_chk(STA, 32'h00000c01);
		wr_reg(CTL, 32'h00000000);
		tick(3);
		rd_chk(STA, 32'h00000c00);
		done("init");
		// sleep entry flag: set, write 0 ignored, write 1 clears
		wr_reg(IEN, 32'h00020000);
		wr_reg(CTL, 32'h00000002);
		tick(3);
		rd_chk(STA, 32'h00000c12);
		wr_reg(STA, 32'h00000000);
		rd_chk(STA, 32'h00000c12);
		wr_reg(STA, 32'h00000010);
		rd_chk(STA, 32'h00000c02);
		// frame start while asleep with auto wake
		wr_reg(IEN, 32'h00030000);
		wr_reg(CTL, 32'h00000022);
		bus_node_model_i.frame_start();
		tick(3);
		check(32'(slp), 32'h0);
		rd_chk(CTL, 32'h00000020);
		rd_chk(STA, 32'h00000c08);
		wr_reg(STA, 32'h00000008);
		done("sleep_wake");
		// error flag only with its enable
		pulse(0);
		rd_chk(STA, 32'h00000c00);
		wr_reg(IEN, 32'h00008000);
		pulse(0);
		rd_chk(STA, 32'h00000c04);
		wr_reg(STA, 32'h00000004);
		rd_chk(STA, 32'h00000c00);
		// activity and line levels
		tx_act <= 1'b1;
		rd_chk(STA, 32'h00000d00);
		tx_act <= 1'b0;
		rx_act <= 1'b1;
		rd_chk(STA, 32'h00000e00);
		rx_act <= 1'b0;
		bus_node_model_i.send(1, 1'b0);
		rd_chk(STA, 32'h00000000);
		bus_node_model_i.let_go();
		rd_chk(STA, 32'h00000800);
		bus_node_model_i.send(1, 1'b1);
		rd_chk(STA, 32'h00000c00);
		done("flags_levels");
		// automatic recovery; a dominant bit restarts the run
		wr_reg(CTL, 32'h00000040);
		pulse(1);
		tick(1);
		check(32'(boff), 32'h1);
		bus_node_model_i.send(1, 1'b1);
		bus_node_model_i.send(1, 1'b0);
		bus_node_model_i.send(3, 1'b1);
		tick(2);
		check(32'(boff), 32'h1);
		bus_node_model_i.send(1, 1'b1);
		tick(2);
		check(32'(boff), 32'h0);
		// manual recovery counts only after init set then cleared
		wr_reg(CTL, 32'h00000000);
		pulse(1);
		bus_node_model_i.send(4, 1'b1);
		tick(2);
		check(32'(boff), 32'h1);
		wr_reg(CTL, 32'h00000001);
		tick(3);
		check(32'(ini), 32'h1);
		wr_reg(CTL, 32'h00000000);
		bus_node_model_i.send(4, 1'b1);
		tick(2);
		check(32'(boff), 32'h0);
		done("bus_off");
		// software reset reloads everything and sleeps
		wr_reg(CTL, 32'h00008000);
		tick(3);
		check({31'(rst_cnt), slp}, 32'h3);
		rd_chk(CTL, 32'h00010002);
		rd_chk(IEN, 32'h00000000);
		// sleep to init with only the init request written, then init straight to sleep
		wr_reg(IEN, 32'h00020000);
		wr_reg(CTL, 32'h00000001);
		tick(2);
		check(32'({slp, ini}), 32'h1);
		wr_reg(CTL, 32'h00000002);
		tick(2);
		rd_chk(STA, 32'h00000c12);
		done("soft_reset");
		summarize();
	end
endmodule // can_mode_control_test
